// ==== core/funcmap_pkg.sv ====
// Constants for the function-to-port and function-to-host-bus assignment block.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package funcmap_pkg;
  localparam int NUM_PORTS  = 4;
  localparam int NUM_BUSES  = 2;
  localparam int NUM_FUNCS  = 16;
  localparam int MAX_WORDS  = NUM_PORTS + 1 + NUM_BUSES;
  localparam int WCNT_W     = 3;
  localparam int PORT_W     = 2;
  localparam int FUNC_W     = 5;
  localparam int BUS_W      = 1;

  localparam logic [31:0] FUNC_MASK      = 32'h0000ffff;
  localparam logic [7:0]  CMD_SET_ASSIGN = 8'h28;

  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CAPS     = 8'h04;
  localparam logic [7:0] OFS_CMD_DATA = 8'h08;
  localparam logic [7:0] OFS_CMD_CODE = 8'h0c;
  localparam logic [7:0] OFS_RESP     = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_ENABLE   = 8'h18;
  localparam logic [7:0] OFS_EN_COUNT = 8'h1c;
  localparam logic [7:0] OFS_PART_SEL = 8'h20;
  localparam logic [7:0] OFS_PART_IDX = 8'h24;
  localparam logic [7:0] OFS_PORT_MAP = 8'h40;
  localparam logic [7:0] OFS_BUS_MAP  = 8'h60;

  localparam int CTRL_MULTI_BIT = 0;
  localparam int STAT_PEND_BIT  = 0;
  localparam int STAT_RESP_BIT  = 1;
  localparam int STAT_WCNT_LSB  = 8;
  localparam int CAPS_BUS_LSB   = 8;
  localparam int CAPS_FUNC_LSB  = 16;
  localparam int SEL_FUNC_LSB   = 8;

  localparam logic [15:0] RESP_OK        = 16'h0000;
  localparam logic [15:0] RESP_FAIL      = 16'h0001;
  localparam logic [15:0] RESP_UNSUP     = 16'h0003;
  localparam logic [15:0] REASON_NONE    = 16'h0000;
  localparam logic [15:0] REASON_LENGTH  = 16'h0001;
  localparam logic [15:0] REASON_UNKNOWN = 16'h7fff;

  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  localparam logic [3:0] STRB_ALL   = 4'hf;
endpackage : funcmap_pkg

// ==== core/funcmap_core.sv ====
// Function assignment command interpreter with AXI4-Lite register access.
// Assumes HOST_BUS_RESET is an asynchronous pin; all else runs on CLK_SYS.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Enable readback is 32 bits, bit n set when function n enabled.
// - Count of enabled bits equals the held enabled function count.
// - A function may be enabled and on a bus with no port mapping.
// - Both bus bitmaps are reported, even when the advertised bus count is one.
// - Bus bitmap bit n set when function n mapped there, enabled or not.
// - Partition index counts mapped functions upward from 1 per port.
// - Mapped functions get a partition index even when disabled.
// - Assignment write uses command code 0x28, addressed to the package.
// - All bitmaps start at bit 0, contiguous up to the function count.
// - Single host interface carries no bus bitmap fields.
// - Single-bus configuration places every function on bus 0.
// - Written values stay pending until the next host bus reset.
// - Payload order is port bitmaps, enable, bus bitmaps.
// - Port bitmap bit n set when function n mapped, enabled or not.
// - Enable bitmap bit n set enables function n, clear disables.
// - Every assignment command returns a response and reason code.
module funcmap_core (
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST_N,
  input  wire logic                    HOST_BUS_RESET,
  input  wire logic [7:0]              S_AXI_AWADDR,
  input  wire logic                    S_AXI_AWVALID,
  output var  logic                    S_AXI_AWREADY,
  input  wire logic [31:0]             S_AXI_WDATA,
  input  wire logic [3:0]              S_AXI_WSTRB,
  input  wire logic                    S_AXI_WVALID,
  output var  logic                    S_AXI_WREADY,
  output var  logic [1:0]              S_AXI_BRESP,
  output var  logic                    S_AXI_BVALID,
  input  wire logic                    S_AXI_BREADY,
  input  wire logic [7:0]              S_AXI_ARADDR,
  input  wire logic                    S_AXI_ARVALID,
  output var  logic                    S_AXI_ARREADY,
  output var  logic [31:0]             S_AXI_RDATA,
  output var  logic [1:0]              S_AXI_RRESP,
  output var  logic                    S_AXI_RVALID,
  input  wire logic                    S_AXI_RREADY
);
  import funcmap_pkg::*;

  logic [31:0]       port_act_ff [NUM_PORTS];
  logic [31:0]       bus_act_ff  [NUM_BUSES];
  logic [31:0]       en_act_ff;
  logic [31:0]       port_pend_ff [NUM_PORTS];
  logic [31:0]       bus_pend_ff  [NUM_BUSES];
  logic [31:0]       en_pend_ff;
  logic [31:0]       cmd_buf_ff [MAX_WORDS];
  logic              pend_valid_ff, resp_valid_ff, multi_ff, ovf_ff;
  logic [WCNT_W-1:0] wcnt_ff;
  logic [31:0]       resp_ff, part_sel_ff, part_idx_ff, en_count_ff;
  logic [7:0]        code_ff;
  logic              sync1_ff, sync2_ff, sync3_ff, rst_lvl_ff;
  logic              aw_have_ff, w_have_ff;
  logic [7:0]        awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;

  // Host bus reset pin: three stages, a rise counts once stages two and three agree.
  wire bus_rst_evt = sync2_ff & sync3_ff & ~rst_lvl_ff;
  always_ff @(posedge CLK_SYS or negedge RST_N)
    if (!RST_N)
    begin
      sync1_ff   <= 1'b0;
      sync2_ff   <= 1'b0;
      sync3_ff   <= 1'b0;
      rst_lvl_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= HOST_BUS_RESET;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff)
        rst_lvl_ff <= sync3_ff;
    end

  // Write channel: address and data taken in either order, then one response.
  wire       wr_fire  = aw_have_ff & w_have_ff & ~S_AXI_BVALID;
  wire       wr_full  = wstrb_ff == STRB_ALL;
  wire [7:0] wa       = awaddr_ff;
  wire       wr_ctrl  = wr_fire & wr_full & (wa == OFS_CTRL);
  wire       wr_data  = wr_fire & wr_full & (wa == OFS_CMD_DATA);
  wire       wr_code  = wr_fire & wr_full & (wa == OFS_CMD_CODE);
  wire       wr_sel   = wr_fire & wr_full & (wa == OFS_PART_SEL);
  wire       wr_ok    = wr_full & (wa == OFS_CTRL | wa == OFS_CMD_DATA | wa == OFS_CMD_CODE | wa == OFS_PART_SEL);

  // Word count the command must carry; bus bitmaps only with more than one bus.
  wire [WCNT_W-1:0] exp_words = multi_ff ? WCNT_W'(MAX_WORDS) : WCNT_W'(NUM_PORTS + 1);
  wire              code_hit  = wdata_ff[7:0] == CMD_SET_ASSIGN;
  wire              len_ok    = ~ovf_ff & (wcnt_ff == exp_words);
  wire              accept    = wr_code & code_hit & len_ok;

  always_ff @(posedge CLK_SYS or negedge RST_N)
    if (!RST_N)
    begin
      aw_have_ff    <= 1'b0;
      w_have_ff     <= 1'b0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= AXI_OKAY;
    end
    else
    begin
      S_AXI_AWREADY <= ~aw_have_ff & ~(S_AXI_AWVALID & S_AXI_AWREADY);
      S_AXI_WREADY  <= ~w_have_ff & ~(S_AXI_WVALID & S_AXI_WREADY);
      if (S_AXI_AWVALID & S_AXI_AWREADY)
      begin
        aw_have_ff <= 1'b1;
        awaddr_ff  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID & S_AXI_WREADY)
      begin
        w_have_ff <= 1'b1;
        wdata_ff  <= S_AXI_WDATA;
        wstrb_ff  <= S_AXI_WSTRB;
      end
      if (wr_fire)
      begin
        aw_have_ff   <= 1'b0;
        w_have_ff    <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
      end
      else if (S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end

  // Command buffer, pending set and active set.
  always_ff @(posedge CLK_SYS or negedge RST_N)
    if (!RST_N)
    begin
      for (int i = 0; i < MAX_WORDS; i++)
        cmd_buf_ff[i] <= 32'h0000_0000;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        port_pend_ff[p] <= 32'h0000_0000;
        port_act_ff[p]  <= 32'h0000_0000;
      end
      for (int b = 0; b < NUM_BUSES; b++)
      begin
        bus_pend_ff[b] <= 32'h0000_0000;
        bus_act_ff[b]  <= 32'h0000_0000;
      end
      en_pend_ff    <= 32'h0000_0000;
      en_act_ff     <= 32'h0000_0000;
      pend_valid_ff <= 1'b0;
      resp_valid_ff <= 1'b0;
      resp_ff       <= 32'h0000_0000;
      code_ff       <= 8'h00;
      wcnt_ff       <= '0;
      ovf_ff        <= 1'b0;
      multi_ff      <= 1'b0;
      part_sel_ff   <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl)
        multi_ff <= wdata_ff[CTRL_MULTI_BIT];
      if (wr_sel)
        part_sel_ff <= wdata_ff;
      if (wr_data)
      begin
        if (wcnt_ff == WCNT_W'(MAX_WORDS))
          ovf_ff <= 1'b1;
        else
        begin
          cmd_buf_ff[wcnt_ff] <= wdata_ff & FUNC_MASK;
          wcnt_ff             <= wcnt_ff + 1'b1;
        end
      end
      // A pending set is applied on the host bus reset, before a new one lands.
      if (bus_rst_evt && pend_valid_ff)
      begin
        for (int p = 0; p < NUM_PORTS; p++)
          port_act_ff[p] <= port_pend_ff[p];
        for (int b = 0; b < NUM_BUSES; b++)
          bus_act_ff[b] <= bus_pend_ff[b];
        en_act_ff     <= en_pend_ff;
        pend_valid_ff <= 1'b0;
      end
      if (wr_code)
      begin
        wcnt_ff       <= '0;
        ovf_ff        <= 1'b0;
        code_ff       <= wdata_ff[7:0];
        resp_valid_ff <= 1'b1;
        if (!code_hit)
          resp_ff <= {RESP_UNSUP, REASON_UNKNOWN};
        else if (!len_ok)
          resp_ff <= {RESP_FAIL, REASON_LENGTH};
        else
          resp_ff <= {RESP_OK, REASON_NONE};
      end
      if (accept)
      begin
        for (int p = 0; p < NUM_PORTS; p++)
          port_pend_ff[p] <= cmd_buf_ff[p];
        en_pend_ff <= cmd_buf_ff[NUM_PORTS];
        for (int b = 0; b < NUM_BUSES; b++)
          bus_pend_ff[b] <= multi_ff ? cmd_buf_ff[NUM_PORTS + 1 + b] : 32'h0000_0000;
        pend_valid_ff <= 1'b1;
      end
    end

  // Bus bitmaps as reported: single-bus mode puts every function on bus 0.
  logic [31:0] bus_rep [NUM_BUSES];
  always_comb
    for (int b = 0; b < NUM_BUSES; b++)
      if (multi_ff)
        bus_rep[b] = bus_act_ff[b];
      else
        bus_rep[b] = (b == 0) ? FUNC_MASK : 32'h0000_0000;

  // Partition index: rank of the selected function among the port's mapped ones.
  wire [PORT_W-1:0] sel_port = part_sel_ff[PORT_W-1:0];
  wire [FUNC_W-1:0] sel_func = part_sel_ff[SEL_FUNC_LSB +: FUNC_W];
  logic [31:0] nxt_part_idx, nxt_en_count;
  always_comb
  begin
    nxt_part_idx = 32'h0000_0000;
    nxt_en_count = 32'h0000_0000;
    for (int f = 0; f < NUM_FUNCS; f++)
    begin
      if (port_act_ff[sel_port][f] && f <= int'(sel_func))
        nxt_part_idx = nxt_part_idx + 32'h0000_0001;
      if (en_act_ff[f])
        nxt_en_count = nxt_en_count + 32'h0000_0001;
    end
    if (!port_act_ff[sel_port][sel_func])
      nxt_part_idx = 32'h0000_0000;
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
    if (!RST_N)
    begin
      part_idx_ff <= 32'h0000_0000;
      en_count_ff <= 32'h0000_0000;
    end
    else
    begin
      part_idx_ff <= nxt_part_idx;
      en_count_ff <= nxt_en_count;
    end

  // Read decode.
  wire [7:0]  ra      = S_AXI_ARADDR;
  wire        ra_port = (ra >= OFS_PORT_MAP) && (ra < OFS_PORT_MAP + 8'(4 * NUM_PORTS)) && (ra[1:0] == 2'b00);
  wire        ra_bus  = (ra >= OFS_BUS_MAP) && (ra < OFS_BUS_MAP + 8'(4 * NUM_BUSES)) && (ra[1:0] == 2'b00);
  wire [7:0]  ra_port_ofs = ra - OFS_PORT_MAP;
  wire [7:0]  ra_bus_ofs  = ra - OFS_BUS_MAP;
  wire [7:0]  caps_buses  = multi_ff ? 8'(NUM_BUSES) : 8'h01;
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    if (ra_port)
      rd_mux = port_act_ff[ra_port_ofs[2 +: PORT_W]];
    else if (ra_bus)
      rd_mux = bus_rep[ra_bus_ofs[2 +: BUS_W]];
    else
      unique case (ra)
        OFS_CTRL:     rd_mux[CTRL_MULTI_BIT] = multi_ff;
        OFS_CAPS:     rd_mux = {8'h00, 8'(NUM_FUNCS), caps_buses, 8'(NUM_PORTS)};
        OFS_CMD_CODE: rd_mux[7:0] = code_ff;
        OFS_RESP:     rd_mux = resp_ff;
        OFS_STATUS:   rd_mux = {20'h00000, 1'b0, wcnt_ff, 6'h00, resp_valid_ff, pend_valid_ff};
        OFS_ENABLE:   rd_mux = en_act_ff;
        OFS_EN_COUNT: rd_mux = en_count_ff;
        OFS_PART_SEL: rd_mux = part_sel_ff;
        OFS_PART_IDX: rd_mux = part_idx_ff;
        default:      rd_hit = 1'b0;
      endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
    if (!RST_N)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= AXI_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= ~S_AXI_RVALID & ~(S_AXI_ARVALID & S_AXI_ARREADY);
      if (S_AXI_ARVALID & S_AXI_ARREADY)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_mux;
        S_AXI_RRESP  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
      end
      else if (S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end

  en_count_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ##1 en_count_ff == 32'($countones($past(en_act_ff)))) else $error("Enable count mismatch.");
  upper_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (en_act_ff & ~FUNC_MASK) == 32'h0 && (port_act_ff[0] & ~FUNC_MASK) == 32'h0) else $error("Bits above count set.");
  apply_reset_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    bus_rst_evt && pend_valid_ff |=> en_act_ff == $past(en_pend_ff)) else $error("Pending set not applied.");
  hold_active_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !bus_rst_evt |=> $stable(en_act_ff) && $stable(port_act_ff[0])) else $error("Active set changed early.");
  code_accept_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wr_code && !code_hit |=> !$changed(en_pend_ff) && resp_ff[31:16] == RESP_UNSUP) else $error("Wrong code taken.");
  resp_given_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wr_code |=> resp_valid_ff && ((resp_ff == {RESP_OK, REASON_NONE}) == $past(accept)))
    else $error("No response to command.");
  single_bus_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !multi_ff |-> bus_rep[0] == FUNC_MASK && bus_rep[1] == 32'h0) else $error("Single bus map wrong.");
  part_index_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    port_act_ff[sel_port][sel_func] && $stable(part_sel_ff) |=> part_idx_ff != 32'h0) else $error("Mapped gets no index.");
  part_first_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ##1 ($past(port_act_ff[sel_port]) & ((32'h2 << $past(sel_func)) - 32'h1)) == (32'h1 << $past(sel_func))
    |-> part_idx_ff == 32'h1) else $error("Lowest mapped not index one.");
  resp_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("Write response dropped.");

endmodule : funcmap_core

`default_nettype wire

// ==== verification/mgmt_master.sv ====
// Management-side master model: issues AXI4-Lite writes, reads and assignment commands.
// Assumes one rising-edge clock shared with the slave and that reset has been released.
`timescale 1ns/1ps
`default_nettype none
module mgmt_master (
  input  wire logic        clk,
  output var  logic [7:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [7:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  import funcmap_pkg::*;
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Released address and data lines show the inverse of the last value; strobes hold.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} <= {a, 1'b1, d, s, 1'b1, 1'b1};
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (!aw_ok && awready)
      begin
        {awvalid, awaddr} <= {1'b0, ~a};
        aw_ok = 1'b1;
      end
      if (!w_ok && wready)
      begin
        {wvalid, wdata} <= {1'b0, ~d};
        w_ok = 1'b1;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 1'b1, 1'b1};
    do @(posedge clk); while (arready !== 1'b1);
    {araddr, arvalid} <= {~a, 1'b0};
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // Payload goes out as port maps, enable, then bus maps in multi-bus mode, then the code.
  task automatic send_cmd(input logic [3:0][31:0] pm, input logic [31:0] en, input logic [1:0][31:0] bm,
                          input logic multi, output logic [1:0] r);
    for (int p = 0; p < NUM_PORTS; p++) wr(OFS_CMD_DATA, pm[p], STRB_ALL, r);
    wr(OFS_CMD_DATA, en, STRB_ALL, r);
    if (multi)
      for (int b = 0; b < NUM_BUSES; b++) wr(OFS_CMD_DATA, bm[b], STRB_ALL, r);
    wr(OFS_CMD_CODE, {24'h0, CMD_SET_ASSIGN}, STRB_ALL, r);
  endtask : send_cmd
endmodule : mgmt_master
`default_nettype wire

// ==== verification/test_function_partition_assignment.sv ====
// Self-checking bench for the function assignment block.
// Assumes the management master model drives the register bus.
`timescale 1ns/1ps
`default_nettype none
module test_function_partition_assignment;
  import funcmap_pkg::*;
  typedef struct packed {logic [3:0][31:0] pm; logic [31:0] en; logic [1:0][31:0] bm; logic multi;} row_t;
  localparam row_t ROWS [3] = '{
    '{{32'hffff8000, 32'h0, 32'h3, 32'h44}, 32'h00010005, {32'h0, 32'h0}, 1'b0},
    '{{32'h0, 32'hf0, 32'h0, 32'h100}, 32'hffff, {32'hff00, 32'hff}, 1'b1},
    '{{32'h0, 32'h0, 32'h0, 32'h0}, 32'h0, {32'h0, 32'h0}, 1'b0}};
  logic        clk_sys;
  logic        rst_n;
  logic        host_rst;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d, e, m, prev_en;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  row_t        rw;
  int          errors, cmp_count, k;
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  funcmap_core dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .HOST_BUS_RESET(host_rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));
  mgmt_master mgr_u (.clk(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] v;
    logic [1:0]  rr;
    mgr_u.rd(a, v, rr);
    chk(nm, ex, v);
  endtask : rc
  task automatic tally_and_finish;
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #500us;
    errors++;
    tally_and_finish();
  end
  initial
  begin
    {rst_n, host_rst, errors, cmp_count, prev_en} = '0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rc("caps", OFS_CAPS, 32'h00100104);
    rc("enable", OFS_ENABLE, 32'h0);
    rc("status", OFS_STATUS, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      rw = ROWS[i];
      mgr_u.wr(OFS_CTRL, {31'h0, rw.multi}, STRB_ALL, r);
      mgr_u.send_cmd(rw.pm, rw.en, rw.bm, rw.multi, r);
      rc("resp", OFS_RESP, 32'h0);
      rc("pending", OFS_STATUS, 32'h3);
      rc("held", OFS_ENABLE, prev_en);
      host_rst <= 1'b1;
      k = 0;
      do
      begin
        mgr_u.rd(OFS_STATUS, d, r);
        k++;
      end while (d[0] !== 1'b0 && k < 20);
      host_rst <= 1'b0;
      chk("applied", 32'h0, 32'(d[0]));
      e = rw.en & FUNC_MASK;
      rc("enable", OFS_ENABLE, e);
      rc("count", OFS_EN_COUNT, 32'($countones(e)));
      rc("caps", OFS_CAPS, {16'h0010, rw.multi ? 8'h2 : 8'h1, 8'h4});
      for (int p = 0; p < NUM_PORTS; p++)
        rc("port map", OFS_PORT_MAP + 8'(4 * p), rw.pm[p] & FUNC_MASK);
      for (int p = 0; p < NUM_BUSES; p++)
        rc("bus map", OFS_BUS_MAP + 8'(4 * p),
           rw.multi ? rw.bm[p] & FUNC_MASK : (p == 0 ? FUNC_MASK : 32'h0));
      for (int p = 0; p < NUM_PORTS; p++)
        for (int f = 0; f < NUM_FUNCS; f++)
        begin
          m = rw.pm[p] & FUNC_MASK & ((32'h1 << f) - 32'h1);
          mgr_u.wr(OFS_PART_SEL, {19'h0, 5'(f), 6'h0, 2'(p)}, STRB_ALL, r);
          repeat (2) @(posedge clk_sys);
          rc("partition", OFS_PART_IDX, rw.pm[p][f] ? 32'($countones(m)) + 32'h1 : 32'h0);
        end
      prev_en = e;
    end
    rc("part sel", OFS_PART_SEL, 32'h00000f03);
    mgr_u.wr(OFS_CMD_CODE, 32'h27, STRB_ALL, r);
    rc("unknown code", OFS_RESP, 32'h00037fff);
    rc("code", OFS_CMD_CODE, 32'h00000027);
    mgr_u.wr(OFS_CMD_DATA, 32'h1, STRB_ALL, r);
    rc("words", OFS_STATUS, 32'h00000102);
    mgr_u.wr(OFS_CMD_CODE, {24'h0, CMD_SET_ASSIGN}, STRB_ALL, r);
    rc("short", OFS_RESP, 32'h00010001);
    rc("no pend", OFS_STATUS, 32'h2);
    mgr_u.wr(OFS_CTRL, 32'h1, 4'h1, r);
    chk("strobe resp", 32'(AXI_SLVERR), 32'(r));
    rc("ctrl", OFS_CTRL, 32'h0);
    mgr_u.wr(OFS_ENABLE, 32'h1, STRB_ALL, r);
    chk("ro resp", 32'(AXI_SLVERR), 32'(r));
    rc("ro kept", OFS_ENABLE, 32'h0);
    mgr_u.rd(8'h80, d, r);
    chk("unmapped resp", 32'(AXI_SLVERR), 32'(r));
    chk("unmapped data", 32'h0, d);
    mgr_u.rd(OFS_CMD_DATA, d, r);
    chk("wo resp", 32'(AXI_SLVERR), 32'(r));
    mgr_u.wr(OFS_CTRL, 32'h1, STRB_ALL, r);
    for (int i = 0; i < 8; i++)
      mgr_u.wr(OFS_CMD_DATA, 32'h1, STRB_ALL, r);
    rc("words full", OFS_STATUS, 32'h00000702);
    mgr_u.wr(OFS_CMD_CODE, {24'h0, CMD_SET_ASSIGN}, STRB_ALL, r);
    rc("overflow", OFS_RESP, 32'h00010001);
    mgr_u.wr(OFS_CTRL, 32'h0, STRB_ALL, r);
    rw = ROWS[0];
    mgr_u.send_cmd(rw.pm, rw.en, rw.bm, rw.multi, r);
    rc("pre reset", OFS_STATUS, 32'h3);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rc("reset status", OFS_STATUS, 32'h0);
    tally_and_finish();
  end
endmodule : test_function_partition_assignment
`default_nettype wire
